// >>> rtl/tmc_regs.sv
// Summary of operation
// - Low byte bits 7..1 hold second carrier word low seven bits, reset 124.
// - Low byte bit 0 enables second carrier dithering, resets to one.
// - Reference divisor code 1 divides by 2, 7 by 8; 0 unsupported; reset 2.
// - First modem divider codes 0..7 give 2.5,3,4,7.5,12.5,40,48,64; reset 4.
// - Second modem divider codes 0..3 give 1,2,4,8; reset 0.
// - Modem clock is reference divided by product of both modem dividers.
// - Symbol rate is modem clock divided by eight.
// - First oscillator bias code, sixteen rising steps, reset 8.
// - Second oscillator bias code, same steps, reset 8.
// - Scramble enable applies PN9 x^9+x^5+1 to transmit data in NRZ and Manchester formats, not UART; reset off.
// - Format 00 NRZ, 01 Manchester, 10/11 UART with data clock low/high.
// - Deviation bit 7 enables Gaussian shaping, resets to one.
// - Lower band deviation is reference times mantissa times 2^(exp-16).
// - Upper band deviation is reference times mantissa times 2^(exp-15).
// - Zero mantissa selects on-off keying instead of FSK.
// - Band choice zero selects lower band, one selects upper band.
//
// Implementation choice: register access over Avalon-MM.
module tmc_regs
  import tmc_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        reset_n_i,
  // Avalon-MM slave
  input  wire logic [AW-1:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // First carrier settings held elsewhere
  input  wire logic [7:0]  first_clocking_i,
  input  wire logic        first_dither_en_i,
  // Modulator side
  input  wire logic        tx_data_i,
  output logic             tx_symbol_o,
  output logic             baud_tick_o,
  output logic             data_clock_out_o,
  output logic             shaping_en_o,
  output logic             ook_en_o,
  output logic [11:0]      dev_step_o,
  output logic             band_choice_o,
  // Synthesiser side
  output logic [3:0]       osc_core_bias_o,
  output logic             dither_en_o,
  output logic [6:0]       second_carrier_word_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] word_low_r;
  logic [7:0] clocking_r;
  logic [7:0] osc_r;
  logic [7:0] modem_r;
  logic [7:0] dev_r;
  logic [7:0] carrier_r;
  logic [7:0] status_r;

  logic [5:0] idx;
  logic       wr_en;
  logic [7:0] rd_nxt;

  assign idx   = avs_address_i[7:2];
  // Write lands on the edge where the master sees waitrequest low
  assign wr_en = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];

  // ----------------------------------------------------------------
  // Bus handshake: one wait cycle per access
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !((avs_read_i || avs_write_i) &&
                             avs_waitrequest_o);
    end
  end

  always_comb begin
    case (idx)
      TMC_IDX_WORD_LOW: rd_nxt = word_low_r;
      TMC_IDX_CLOCKING: rd_nxt = clocking_r;
      TMC_IDX_OSC:      rd_nxt = osc_r;
      TMC_IDX_MODEM:    rd_nxt = modem_r;
      TMC_IDX_DEV:      rd_nxt = dev_r;
      TMC_IDX_CARRIER:  rd_nxt = carrier_r;
      TMC_IDX_STATUS:   rd_nxt = status_r;
      default:          rd_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= {24'h00_0000, rd_nxt};
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_low_r <= TMC_RST_WORD_LOW;
      clocking_r <= TMC_RST_CLOCKING;
      osc_r      <= TMC_RST_OSC;
      modem_r    <= TMC_RST_MODEM;
      dev_r      <= TMC_RST_DEV;
      carrier_r  <= TMC_RST_CARRIER;
    end else if (wr_en) begin
      case (idx)
        TMC_IDX_WORD_LOW: word_low_r <= avs_writedata_i[7:0];
        TMC_IDX_CLOCKING: clocking_r <= avs_writedata_i[7:0];
        TMC_IDX_OSC:      osc_r      <= avs_writedata_i[7:0];
        TMC_IDX_MODEM:    modem_r    <= avs_writedata_i[7:0];
        TMC_IDX_DEV:      dev_r      <= avs_writedata_i[7:0];
        TMC_IDX_CARRIER:  carrier_r  <= avs_writedata_i[7:0];
        default:          carrier_r  <= carrier_r;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Carrier selection of active settings
  // ----------------------------------------------------------------
  logic       sel_second;
  logic [7:0] act_clocking;
  logic [2:0] ref_code;
  logic [2:0] mdiv1_code;
  logic [1:0] mdiv2_code;

  assign sel_second   = carrier_r[TMC_CSEL_BIT];
  // Only the second carrier's dividers live here
  assign act_clocking = sel_second ? clocking_r : first_clocking_i;
  assign ref_code     = act_clocking[TMC_REFDIV_LSB +: 3];
  assign mdiv1_code   = act_clocking[TMC_MDIV1_LSB +: 3];
  assign mdiv2_code   = act_clocking[TMC_MDIV2_LSB +: 2];

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      osc_core_bias_o       <= TMC_RST_OSC[TMC_OSC_A_LSB +: 4];
      dither_en_o           <= 1'b0;
      second_carrier_word_o <= TMC_RST_WORD_LOW[TMC_WORD_LSB +: 7];
    end else begin
      if (sel_second) begin
        osc_core_bias_o <= osc_r[TMC_OSC_B_LSB +: 4];
        dither_en_o     <= word_low_r[TMC_DITHER_BIT];
      end else begin
        osc_core_bias_o <= osc_r[TMC_OSC_A_LSB +: 4];
        dither_en_o     <= first_dither_en_i;
      end
      second_carrier_word_o <= word_low_r[TMC_WORD_LSB +: 7];
    end
  end

  // ----------------------------------------------------------------
  // Reference and modem clock dividers
  // ----------------------------------------------------------------
  logic [11:0] ref_limit;
  logic [11:0] mod_limit;
  logic        ref_tick;
  logic        mod_tick;
  logic [2:0]  eff_ref;

  // Unsupported code 0 runs as code 1 rather than stopping the modem
  assign eff_ref   = (ref_code == TMC_REF_NOSUP) ? TMC_REF_MIN : ref_code;
  assign ref_limit = 12'(eff_ref) + 12'h001;
  // Second divider is a power of two, so the product is a shift
  assign mod_limit = 12'(tmc_mdiv1_x2(mdiv1_code))
                     << mdiv2_code;

  tmc_frac_div #(
    .W (12)
  ) u_ref_div (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .en_i      (1'b1),
    .step_i    (12'h001),
    .limit_i   (ref_limit),
    .tick_o    (ref_tick)
  );

  // Counts two per reference tick so ratios like 2.5 come out exact
  tmc_frac_div #(
    .W (12)
  ) u_mod_div (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .en_i      (ref_tick),
    .step_i    (12'h002),
    .limit_i   (mod_limit),
    .tick_o    (mod_tick)
  );

  // ----------------------------------------------------------------
  // Symbol timing
  // ----------------------------------------------------------------
  logic [2:0] phase_r;
  logic       baud_nxt;

  assign baud_nxt = mod_tick && (phase_r == TMC_BAUD_LAST);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_r     <= 3'h0;
      baud_tick_o <= 1'b0;
    end else begin
      if (mod_tick) begin
        phase_r <= phase_r + 3'h1;
      end
      baud_tick_o <= baud_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Scrambler and data format
  // ----------------------------------------------------------------
  logic [8:0] pn_r;
  logic       bit_r;
  logic       scram_en;
  tmc_fmt_t   fmt;

  assign scram_en = modem_r[TMC_SCRAM_BIT];
  assign fmt      = tmc_fmt_t'(modem_r[TMC_FMT_LSB +: 2]);

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pn_r  <= TMC_PN9_SEED;
      bit_r <= 1'b0;
    end else if (!scram_en) begin
      // Reseed while off so each enabled run starts the same sequence
      pn_r <= TMC_PN9_SEED;
      if (baud_nxt) begin
        bit_r <= tx_data_i;
      end
    end else if (baud_nxt) begin
      pn_r  <= {pn_r[7:0],
                pn_r[TMC_PN9_TAP_HI] ^ pn_r[TMC_PN9_TAP_LO]};
      bit_r <= tx_data_i ^ pn_r[TMC_PN9_TAP_HI];
    end
  end

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_symbol_o      <= 1'b0;
      data_clock_out_o <= 1'b0;
    end else begin
      case (fmt)
        TMC_FMT_NRZ: begin
          tx_symbol_o      <= bit_r;
          data_clock_out_o <= (phase_r >= TMC_HALF_BAUD);
        end
        TMC_FMT_MANCH: begin
          tx_symbol_o      <= bit_r ^ (phase_r >= TMC_HALF_BAUD);
          data_clock_out_o <= (phase_r >= TMC_HALF_BAUD);
        end
        TMC_FMT_UART_LO: begin
          tx_symbol_o      <= tx_data_i;
          data_clock_out_o <= 1'b0;
        end
        TMC_FMT_UART_HI: begin
          tx_symbol_o      <= tx_data_i;
          data_clock_out_o <= 1'b1;
        end
        default: begin
          tx_symbol_o      <= 1'b0;
          data_clock_out_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Deviation and keying
  // ----------------------------------------------------------------
  logic [3:0] dev_m;
  logic [2:0] dev_x;
  logic       band;

  assign dev_m = dev_r[TMC_DEVM_LSB +: 4];
  assign dev_x = dev_r[TMC_DEVX_LSB +: 3];
  assign band  = carrier_r[TMC_BAND_BIT];

  // Step is in units of reference/2^16; upper band doubles it
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dev_step_o    <= 12'h000;
      ook_en_o      <= 1'b0;
      shaping_en_o  <= 1'b1;
      band_choice_o <= 1'b1;
    end else begin
      if (band) begin
        dev_step_o <= (12'(dev_m) << dev_x) << 1;
      end else begin
        dev_step_o <= 12'(dev_m) << dev_x;
      end
      ook_en_o      <= (dev_m == 4'h0);
      shaping_en_o  <= dev_r[TMC_SHAPE_BIT];
      band_choice_o <= band;
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      status_r <= 8'h00;
    end else begin
      status_r <= {4'h0, tx_symbol_o, scram_en,
                   ref_code == TMC_REF_NOSUP, dev_m == 4'h0};
    end
  end

endmodule // tmc_regs

// >>> rtl/tmc_pkg.sv
package tmc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [5:0] TMC_IDX_WORD_LOW = 6'h0A;
  localparam logic [5:0] TMC_IDX_CLOCKING = 6'h0B;
  localparam logic [5:0] TMC_IDX_OSC      = 6'h0C;
  localparam logic [5:0] TMC_IDX_MODEM    = 6'h0D;
  localparam logic [5:0] TMC_IDX_DEV      = 6'h0E;
  localparam logic [5:0] TMC_IDX_CARRIER  = 6'h1E;
  localparam logic [5:0] TMC_IDX_STATUS   = 6'h1F;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TMC_RST_WORD_LOW = 8'hF9;
  localparam logic [7:0] TMC_RST_CLOCKING = 8'h50;
  localparam logic [7:0] TMC_RST_OSC      = 8'h88;
  localparam logic [7:0] TMC_RST_MODEM    = 8'h00;
  localparam logic [7:0] TMC_RST_DEV      = 8'hE8;
  localparam logic [7:0] TMC_RST_CARRIER  = 8'h01;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TMC_WORD_LSB   = 1;
  localparam int TMC_DITHER_BIT = 0;
  localparam int TMC_REFDIV_LSB = 5;
  localparam int TMC_MDIV1_LSB  = 2;
  localparam int TMC_MDIV2_LSB  = 0;
  localparam int TMC_OSC_A_LSB  = 4;
  localparam int TMC_OSC_B_LSB  = 0;
  localparam int TMC_SCRAM_BIT  = 2;
  localparam int TMC_FMT_LSB    = 0;
  localparam int TMC_SHAPE_BIT  = 7;
  localparam int TMC_DEVX_LSB   = 4;
  localparam int TMC_DEVM_LSB   = 0;
  localparam int TMC_BAND_BIT   = 0;
  localparam int TMC_CSEL_BIT   = 1;

  // ----------------------------------------------------------------
  // Timing and coding constants
  // ----------------------------------------------------------------
  localparam logic [2:0] TMC_BAUD_LAST  = 3'h7;
  localparam logic [2:0] TMC_HALF_BAUD  = 3'h4;
  localparam logic [8:0] TMC_PN9_SEED   = 9'h1FF;
  localparam int         TMC_PN9_TAP_HI = 8;
  localparam int         TMC_PN9_TAP_LO = 4;
  localparam logic [2:0] TMC_REF_NOSUP  = 3'h0;
  localparam logic [2:0] TMC_REF_MIN    = 3'h1;

  typedef enum logic [1:0] {
    TMC_FMT_NRZ,
    TMC_FMT_MANCH,
    TMC_FMT_UART_LO,
    TMC_FMT_UART_HI
  } tmc_fmt_t;

  // First modem divider ratio, in half steps (2.5 becomes 5)
  function automatic logic [7:0] tmc_mdiv1_x2(input logic [2:0] code);
    case (code)
      3'h0:    tmc_mdiv1_x2 = 8'h05;
      3'h1:    tmc_mdiv1_x2 = 8'h06;
      3'h2:    tmc_mdiv1_x2 = 8'h08;
      3'h3:    tmc_mdiv1_x2 = 8'h0F;
      3'h4:    tmc_mdiv1_x2 = 8'h19;
      3'h5:    tmc_mdiv1_x2 = 8'h50;
      3'h6:    tmc_mdiv1_x2 = 8'h60;
      default: tmc_mdiv1_x2 = 8'h80;
    endcase
  endfunction

endpackage

// >>> rtl/tmc_frac_div.sv
module tmc_frac_div #(
  parameter int W = 12
) (
  // Clock and reset
  input  wire logic         clk_sys_i,
  input  wire logic         reset_n_i,
  // Rate control
  input  wire logic         en_i,
  input  wire logic [W-1:0] step_i,
  input  wire logic [W-1:0] limit_i,
  // Output tick
  output logic              tick_o
);

  logic [W-1:0] acc_r;
  logic [W:0]   sum;

  // Accumulate in fractional units so half-step ratios keep average rate
  assign sum = {1'b0, acc_r} + {1'b0, step_i};

  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      acc_r  <= '0;
      tick_o <= 1'b0;
    end else if (!en_i) begin
      tick_o <= 1'b0;
    end else if (sum >= {1'b0, limit_i}) begin
      // A remainder left over from a longer limit restarts the count,
      // otherwise a rate change would burst ticks until it drained
      acc_r  <= (acc_r >= limit_i) ? '0 : W'(sum - {1'b0, limit_i});
      tick_o <= 1'b1;
    end else begin
      acc_r  <= sum[W-1:0];
      tick_o <= 1'b0;
    end
  end

endmodule // tmc_frac_div

// >>> tb/tmc_regs_checker.sv
module tmc_regs_checker
  import tmc_pkg::*;
#(
  parameter int AW = 8
) (
  // Clock, reset, bus and first carrier dither
  input wire logic          clk_sys_i,
  input wire logic          reset_n_i,
  input wire logic [AW-1:0] avs_address_i,
  input wire logic          avs_read_i,
  input wire logic          avs_write_i,
  input wire logic [31:0]   avs_writedata_i,
  input wire logic [3:0]    avs_byteenable_i,
  input wire logic          avs_waitrequest_o,
  input wire logic          first_dither_en_i,
  // Outputs under watch
  input wire logic          baud_tick_o,
  input wire logic          data_clock_out_o,
  input wire logic          shaping_en_o,
  input wire logic          ook_en_o,
  input wire logic [11:0]   dev_step_o,
  input wire logic          band_choice_o,
  input wire logic [3:0]    osc_core_bias_o,
  input wire logic          dither_en_o,
  input wire logic [6:0]    second_carrier_word_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  // ------------------------------------------------------------
  // Shadow registers
  // ------------------------------------------------------------
  logic [7:0] wl_r, osc_r, mdm_r, dev_r, car_r;
  logic [1:0] quiet_r;
  logic       wr_ok;
  assign wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wl_r  <= TMC_RST_WORD_LOW;
      osc_r <= TMC_RST_OSC;
      mdm_r <= TMC_RST_MODEM;
      dev_r <= TMC_RST_DEV;
      car_r <= TMC_RST_CARRIER;
    end else if (wr_ok) begin
      case (avs_address_i[7:2])
        TMC_IDX_WORD_LOW: wl_r <= avs_writedata_i[7:0];
        TMC_IDX_OSC:      osc_r <= avs_writedata_i[7:0];
        TMC_IDX_MODEM:    mdm_r <= avs_writedata_i[7:0];
        TMC_IDX_DEV:      dev_r <= avs_writedata_i[7:0];
        TMC_IDX_CARRIER:  car_r <= avs_writedata_i[7:0];
        default: ;
      endcase
    end
  end
  // Outputs lag a write by a pipeline stage, so judge them once settled
  always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) quiet_r <= 2'h0;
    else if (wr_ok) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  chk_wait_one: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  chk_wait_back: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  chk_word_low: assert property (
    quiet_r == 2'h3 |-> second_carrier_word_o == wl_r[7:1])
    else $error("carrier word output differs");
  chk_dither_sel: assert property (
    quiet_r == 2'h3 && $stable(first_dither_en_i)
    |-> dither_en_o == (car_r[1] ? wl_r[0] : first_dither_en_i))
    else $error("dither output differs");
  chk_bias_sel: assert property (
    quiet_r == 2'h3
    |-> osc_core_bias_o == (car_r[1] ? osc_r[3:0] : osc_r[7:4]))
    else $error("oscillator bias differs");
  chk_shape_bit: assert property (
    quiet_r == 2'h3 |-> shaping_en_o == dev_r[7])
    else $error("shaping enable differs");
  chk_dev_step: assert property (
    quiet_r == 2'h3
    |-> dev_step_o == ((12'(dev_r[3:0]) << dev_r[6:4]) << car_r[0]))
    else $error("deviation step differs");
  chk_ook_mant: assert property (
    quiet_r == 2'h3 |-> ook_en_o == (dev_r[3:0] == 4'h0))
    else $error("on-off keying flag differs");
  chk_band_bit: assert property (
    quiet_r == 2'h3 |-> band_choice_o == car_r[0])
    else $error("band choice differs");
  chk_uart_clock: assert property (
    quiet_r == 2'h3 && mdm_r[1] |-> data_clock_out_o == mdm_r[0])
    else $error("data clock level wrong in uart mode");
  // Clocked formats: high through the end of a symbol, low as the next opens
  chk_data_clock_out_halves: assert property (
    quiet_r == 2'h3 && !mdm_r[1] && baud_tick_o
    |-> data_clock_out_o ##1 !data_clock_out_o)
    else $error("data clock halves wrong in clocked mode");
  chk_tick_pulse: assert property (baud_tick_o |=> !baud_tick_o)
    else $error("symbol tick longer than one cycle");
endmodule // tmc_regs_checker

bind tmc_regs tmc_regs_checker #(.AW(AW)) chk_i (.clk_sys_i, .reset_n_i,
  .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
  .avs_byteenable_i, .avs_waitrequest_o, .first_dither_en_i, .baud_tick_o,
  .data_clock_out_o, .shaping_en_o, .ook_en_o, .dev_step_o, .band_choice_o,
  .osc_core_bias_o, .dither_en_o, .second_carrier_word_o);

// >>> tb/tmc_host.sv
module tmc_host (
  // Clock and answer
  input  wire logic  clk_sys_i,
  input  wire logic  avs_waitrequest_i,
  // Request
  output logic [7:0]  avs_address_o,
  output logic        avs_read_o,
  output logic        avs_write_o,
  output logic [31:0] avs_writedata_o,
  output logic [3:0]  avs_byteenable_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {avs_address_o, avs_read_o, avs_write_o} = 10'h000;
    {avs_writedata_o, avs_byteenable_o} = 36'h0;
  end
  // Always steps one edge first, so a release is never undone in its slot
  task automatic xfer(input logic rd, input logic [7:0] a,
                      input logic [7:0] d, input logic [3:0] be);
    @(posedge clk_sys_i);
    avs_address_o <= a;
    avs_read_o <= rd;
    avs_write_o <= !rd;
    avs_writedata_o <= {24'h000000, d};
    avs_byteenable_o <= be;
    // No cycle limit here: a slave that never answers is the watchdog's
    do begin
      @(posedge clk_sys_i);
    end while (avs_waitrequest_i !== 1'b0);
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
  endtask
  // Deviation in steps of ref/2^16 turned into exponent and mantissa
  function automatic logic [6:0] dev_pick(input logic [11:0] v);
    int x;
    x = 6;
    while ((v >> x) < 8 && x > 0) x--;
    while ((v >> x) >= 16 && x < 7) x++;
    return {3'(x), 4'(v >> x)};
  endfunction
endmodule // tmc_host

// >>> tb/test_tmc_regs.sv
`define CHK(a, e, m) begin checks++; if ((a) !== (e)) begin failures++; $display("MISMATCH %0t %s", $time, m); end end
module test_tmc_regs;
  import tmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_i = 1'b0, reset_n_i = 1'b0, rd_w, wr_w, wait_w, tx_data_i = 1'b0;
  logic first_dither_en_i = 1'b0, tx_symbol_o, baud_tick_o, data_clock_out_w, shp_w, ook_w;
  logic band_w, dith_w;
  logic [7:0] addr_w, first_clocking_i = 8'h20;
  logic [31:0] wd_w, rdata_w, e, exp_rd;
  logic [3:0] be_w, bias_w;
  logic [11:0] dev_w;
  logic [6:0] word_w;
  logic [31:0] expq[$];
  int failures = 0, checks = 0, seed = 51184, n, c;
  logic [5:0] idx [6] = '{TMC_IDX_WORD_LOW, TMC_IDX_CLOCKING, TMC_IDX_OSC,
                          TMC_IDX_MODEM, TMC_IDX_DEV, TMC_IDX_CARRIER};
  logic [7:0] rv [6] = '{{7'd124, 1'b1}, {3'd2, 3'd4, 2'd0}, {4'd8, 4'd8},
                         8'h00, {1'b1, 3'd6, 4'd8}, 8'h01};
  // Clocking byte, carrier byte and symbol period in clock cycles
  logic [7:0] cb [6] = '{8'h20, 8'h29, 8'h44, 8'hC0, 8'h2C, 8'h44};
  logic [7:0] cs [6] = '{8'h02, 8'h03, 8'h02, 8'h02, 8'h02, 8'h01};
  int per [6] = '{40, 128, 72, 140, 120, 120};
  tmc_host host (.clk_sys_i(clk_sys_i), .avs_waitrequest_i(wait_w),
    .avs_address_o(addr_w), .avs_read_o(rd_w), .avs_write_o(wr_w),
    .avs_writedata_o(wd_w), .avs_byteenable_o(be_w));
  tmc_regs uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
    .avs_address_i(addr_w), .avs_read_i(rd_w), .avs_write_i(wr_w),
    .avs_writedata_i(wd_w), .avs_byteenable_i(be_w), .avs_readdata_o(rdata_w),
    .avs_waitrequest_o(wait_w), .first_clocking_i(first_clocking_i),
    .first_dither_en_i(first_dither_en_i), .tx_data_i(tx_data_i),
    .tx_symbol_o(tx_symbol_o), .baud_tick_o(baud_tick_o),
    .data_clock_out_o(data_clock_out_w), .shaping_en_o(shp_w), .ook_en_o(ook_w),
    .dev_step_o(dev_w), .band_choice_o(band_w), .osc_core_bias_o(bias_w),
    .dither_en_o(dith_w), .second_carrier_word_o(word_w));
  always #50 clk_sys_i = ~clk_sys_i;
  // --------------------------------------------------------------
  // Read data watcher
  // --------------------------------------------------------------
  always @(posedge clk_sys_i) begin
    if (rd_w === 1'b1 && wait_w === 1'b0 && expq.size() > 0) begin
      // Own variable: the main sequence reuses e in this same time step
      exp_rd = expq.pop_front();
      `CHK(rdata_w, exp_rd, "read data")
    end
  end
  task automatic rd(input logic [5:0] i, input logic [7:0] x);
    expq.push_back({24'h000000, x});
    host.xfer(1'b1, {i, 2'b00}, 8'h00, 4'hF);
  endtask
  task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [3:0] be = 4'hF);
    host.xfer(1'b0, {i, 2'b00}, d, be);
  endtask
  // Cycles up to the next symbol tick, bounded
  task automatic tick_wait(output int k);
    k = 0;
    do begin
      @(posedge clk_sys_i);
      k++;
    end while (baud_tick_o !== 1'b1 && k < 3000);
    if (baud_tick_o !== 1'b1) failures++;
  endtask
  task automatic ones(input int ticks, output int cnt);
    int k;
    cnt = 0;
    repeat (4) tick_wait(k);
    repeat (ticks) begin
      tick_wait(k);
      cnt += (tx_symbol_o === 1'b1);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    failures++;
    wrap_up();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    foreach (idx[i]) rd(idx[i], rv[i]);
    rd(6'h10, 8'h00);
    wr(6'h10, 8'hA5);
    rd(6'h10, 8'h00);
    for (int i = 0; i < 5; i++) begin
      e = $random(seed);
      wr(idx[i], e[7:0]);
      rd(idx[i], e[7:0]);
      wr(idx[i], ~e[7:0], 4'h0);
      rd(idx[i], e[7:0]);
    end
    for (int i = 0; i < 4; i++) begin
      e = $random(seed);
      first_clocking_i <= e[7:0];
      first_dither_en_i <= e[8];
      wr(TMC_IDX_CARRIER, 8'(i));
      wr(TMC_IDX_DEV, {e[9], host.dev_pick(12'(8 + {e[31:10]} % 1913))});
      repeat (6) @(posedge clk_sys_i);
    end
    wr(TMC_IDX_DEV, 8'h70);
    rd(TMC_IDX_DEV, 8'h70);
    for (int f = 0; f < 4; f++) begin
      wr(TMC_IDX_MODEM, 8'(f));
      repeat (6) @(posedge clk_sys_i);
    end
    foreach (per[i]) begin
      first_clocking_i <= 8'h2C;
      wr(TMC_IDX_CLOCKING, cb[i]);
      wr(TMC_IDX_CARRIER, cs[i]);
      repeat (3) tick_wait(n);
      tick_wait(n);
      `CHK(n, per[i], "symbol period")
    end
    wr(TMC_IDX_CLOCKING, 8'h20);
    wr(TMC_IDX_CARRIER, 8'h02);
    wr(TMC_IDX_MODEM, 8'h04);
    ones(511, c);
    `CHK(c, 256, "scrambled ones count")
    wr(TMC_IDX_MODEM, 8'h00);
    ones(64, c);
    `CHK(c, 0, "plain zeros passed")
    tx_data_i <= 1'b1;
    ones(64, c);
    `CHK(c, 64, "plain ones passed")
    // Steady ones, scrambler off, second carrier at ref code 1, zero mantissa
    rd(TMC_IDX_STATUS, 8'h09);
    wr(TMC_IDX_STATUS, 8'h00);
    rd(TMC_IDX_STATUS, 8'h09);
    wr(TMC_IDX_MODEM, 8'h01);
    ones(64, c);
    `CHK(c, 0, "manchester late half")
    wrap_up();
  end
endmodule // test_tmc_regs
